/* File: verilog/monitor_regs_pkg.sv */
package monitor_regs_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_RATE = 8'h01;
  localparam logic [7:0] ADDR_TRIGGER = 8'h02;
  localparam logic [7:0] ADDR_MASKS = 8'h03;
  localparam logic [7:0] ADDR_OVER = 8'h04;
  localparam logic [7:0] ADDR_UNDER = 8'h05;
  localparam logic [7:0] ADDR_SAMPLING = 8'h0a;

  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int RATE_LSB = 0;
  localparam int DONE_BIT = 7;
  localparam int CH1_SOURCE_BIT = 0;
  localparam int CH1_SENSE_BIT = 1;
  localparam int CH2_SOURCE_BIT = 2;
  localparam int CH2_SENSE_BIT = 3;
  localparam logic [1:0] RATE_RESET = 2'h3;
  localparam logic [3:0] MASKS_RESET = 4'h0;
  localparam logic [7:0] SAMPLING_RESET = 8'h00;
  localparam logic [3:0] CH2_BITS = 4'hc;
  localparam logic [7:0] SAMPLING_CH2_BITS = 8'hf0;

  // ---------------------------------------------------------------
  // Rate codes
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    RATE_1SPS = 2'h0,
    RATE_2SPS = 2'h1,
    RATE_4SPS = 2'h2,
    RATE_CONT = 2'h3
  } rate_code_t;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 50_000_000;
  localparam int DONE_PULSE_NS = 5000;
  localparam int DONE_PULSE_CYCLES = (DONE_PULSE_NS * (CLK_HZ / 1_000_000)) / 1000;

endpackage

/* File: verilog/limit_flag_if.sv */
`timescale 1ns/1ps
interface limit_flag_if;
  logic set_over;
  logic set_under;
  logic clr;
  logic over;
  logic under;
  modport flag (input set_over, input set_under, input clr, output over, output under);
  modport ctrl (output set_over, output set_under, output clr, input over, input under);
endinterface

/* File: verilog/limit_flag_cell.sv */
`timescale 1ns/1ps
module limit_flag_cell
  import monitor_regs_pkg::*;
#(
  parameter bit PRESENT = 1'b1
) (
  // Clock, enable and reset
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // Flag controls
  limit_flag_if.flag fl
);

  logic over_reg;
  logic over_next;
  logic under_reg;
  logic under_next;

  // Sticky flags: set wins over read clear
  always_comb begin
    over_next = over_reg;
    under_next = under_reg;
    if (fl.clr) begin
      over_next = 1'b0;
      under_next = 1'b0;
    end
    if (fl.set_over) begin
      over_next = 1'b1;
    end
    if (fl.set_under) begin
      under_next = 1'b1;
    end
    if (!PRESENT) begin
      over_next = 1'b0;
      under_next = 1'b0;
    end
  end

  // Flag registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      over_reg <= 1'b0;
      under_reg <= 1'b0;
    end else if (ce) begin
      over_reg <= over_next;
      under_reg <= under_next;
    end
  end

  assign fl.over = over_reg;
  assign fl.under = under_reg;

endmodule

/* File: verilog/monitor_rate_mask_status_regs.sv */
// Contract
// - Rate field bits 1:0 select 1 sps (00), 2 sps (01), 4 sps (10) or continuous (11), resetting to continuous.
// - Unimplemented bits read zero and ignore writes.
// - In standby any write to the trigger register starts one conversion cycle.
// - A set mask bit keeps that measurement's limit violations off the alert output.
// - An over flag sets when the measurement is at or above its high limit.
// - An under flag sets when the measurement is strictly below its low limit.
// - The done flag in bit 7 of the over register sets at cycle end and clears on read of that register.
// - A set, unmasked limit flag asserts the active-low alert when alerting is enabled.
// - Sampling register holds per-channel sample-time fields (7:6, 3:2), reset zero.
// - Sampling register holds per-channel averaging fields (5:4, 1:0).
// - In the single-channel build all channel-2 bits read zero.
// - Limit flags update regardless of the global alert mask.
// - With the done alert enabled, alert pulses low for 5 us at each cycle end.
`timescale 1ns/1ps
module monitor_rate_mask_status_regs
  import monitor_regs_pkg::*;
#(
  parameter bit DUAL = 1'b1
) (
  // Clock, enable and reset
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // Register access from the bus engine
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Configuration bits
  input wire logic global_alert_mask,
  input wire logic cycle_done_alert_pulse,
  input wire logic standby,
  // Conversion engine
  input wire logic cycle_done,
  input wire logic [3:0] meas_valid,
  input wire logic [3:0] at_or_above_high,
  input wire logic [3:0] below_low,
  output logic start_conversion,
  output logic [1:0] sample_rate_code,
  output logic [7:0] sampling_setup,
  // Alert pin
  output logic alert_n
);

  // ---------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------
  logic [1:0] rate_reg;
  logic [1:0] rate_next;
  logic [3:0] masks_reg;
  logic [3:0] masks_next;
  logic [7:0] sampling_reg;
  logic [7:0] sampling_next;
  logic done_reg;
  logic done_next;
  logic start_reg;
  logic start_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic [3:0] over_flags;
  logic [3:0] under_flags;
  logic [3:0] impl_mask;
  logic rd_over;
  logic rd_under;

  assign impl_mask = DUAL ? 4'hf : ~CH2_BITS;
  assign rd_over = reg_rd && (reg_addr == ADDR_OVER);
  assign rd_under = reg_rd && (reg_addr == ADDR_UNDER);

  // ---------------------------------------------------------------
  // Limit flag cells, one per measurement
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_flag
      limit_flag_if fi ();
      assign fi.set_over = meas_valid[g] && at_or_above_high[g];
      assign fi.set_under = meas_valid[g] && below_low[g];
      assign fi.clr = rd_over;
      limit_flag_cell #(
        .PRESENT(DUAL || (g < 2))
      ) u_cell (
        .clk(clk),
        .nrst(nrst),
        .ce(ce),
        .fl(fi.flag)
      );
      assign over_flags[g] = fi.over;
    end
  endgenerate

  // Under flags clear on their own register read
  limit_flag_if ui [4] ();
  generate
    for (g = 0; g < 4; g++) begin : g_under
      assign ui[g].set_over = 1'b0;
      assign ui[g].set_under = meas_valid[g] && below_low[g];
      assign ui[g].clr = rd_under;
      limit_flag_cell #(
        .PRESENT(DUAL || (g < 2))
      ) u_ucell (
        .clk(clk),
        .nrst(nrst),
        .ce(ce),
        .fl(ui[g].flag)
      );
      assign under_flags[g] = ui[g].under;
    end
  endgenerate

  // ---------------------------------------------------------------
  // Writable registers and trigger
  // ---------------------------------------------------------------
  // Next values of the writable registers and the trigger strobe
  always_comb begin
    rate_next = rate_reg;
    masks_next = masks_reg;
    sampling_next = sampling_reg;
    start_next = 1'b0;
    if (reg_wr) begin
      case (reg_addr)
        ADDR_RATE: begin
          rate_next = reg_wdata[RATE_LSB +: 2];
        end
        ADDR_TRIGGER: begin
          start_next = standby;
        end
        ADDR_MASKS: begin
          masks_next = reg_wdata[3:0] & impl_mask;
        end
        ADDR_SAMPLING: begin
          sampling_next = DUAL ? reg_wdata : (reg_wdata & ~SAMPLING_CH2_BITS);
        end
        default: begin
          start_next = 1'b0;
        end
      endcase
    end
  end

  // Writable registers, frozen while the enable is low
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rate_reg <= RATE_RESET;
      masks_reg <= MASKS_RESET;
      sampling_reg <= SAMPLING_RESET;
      start_reg <= 1'b0;
    end else if (ce) begin
      rate_reg <= rate_next;
      masks_reg <= masks_next;
      sampling_reg <= sampling_next;
      start_reg <= start_next;
    end
  end

  // ---------------------------------------------------------------
  // Done flag
  // ---------------------------------------------------------------
  // Done flag next value, set beats read clear
  always_comb begin
    done_next = done_reg;
    if (rd_over) begin
      done_next = 1'b0;
    end
    if (cycle_done) begin
      done_next = 1'b1;
    end
  end

  // Done flag register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      done_reg <= 1'b0;
    end else if (ce) begin
      done_reg <= done_next;
    end
  end

  // ---------------------------------------------------------------
  // Named flag and mask bits
  // ---------------------------------------------------------------
  logic ch1_source_over_flag;
  logic ch1_sense_over_flag;
  logic ch2_source_over_flag;
  logic ch2_sense_over_flag;
  logic ch1_source_under_flag;
  logic ch1_sense_under_flag;
  logic ch2_source_under_flag;
  logic ch2_sense_under_flag;
  logic ch1_source_limit_mask;
  logic ch1_sense_limit_mask;
  logic ch2_source_limit_mask;
  logic ch2_sense_limit_mask;
  logic [3:0] over_view;
  logic [3:0] under_view;
  logic [3:0] mask_view;

  assign ch1_source_over_flag = over_flags[CH1_SOURCE_BIT] & impl_mask[CH1_SOURCE_BIT];
  assign ch1_sense_over_flag = over_flags[CH1_SENSE_BIT] & impl_mask[CH1_SENSE_BIT];
  assign ch2_source_over_flag = over_flags[CH2_SOURCE_BIT] & impl_mask[CH2_SOURCE_BIT];
  assign ch2_sense_over_flag = over_flags[CH2_SENSE_BIT] & impl_mask[CH2_SENSE_BIT];
  assign ch1_source_under_flag = under_flags[CH1_SOURCE_BIT] & impl_mask[CH1_SOURCE_BIT];
  assign ch1_sense_under_flag = under_flags[CH1_SENSE_BIT] & impl_mask[CH1_SENSE_BIT];
  assign ch2_source_under_flag = under_flags[CH2_SOURCE_BIT] & impl_mask[CH2_SOURCE_BIT];
  assign ch2_sense_under_flag = under_flags[CH2_SENSE_BIT] & impl_mask[CH2_SENSE_BIT];
  assign ch1_source_limit_mask = masks_reg[CH1_SOURCE_BIT];
  assign ch1_sense_limit_mask = masks_reg[CH1_SENSE_BIT];
  assign ch2_source_limit_mask = masks_reg[CH2_SOURCE_BIT];
  assign ch2_sense_limit_mask = masks_reg[CH2_SENSE_BIT];
  // Register views in bit order, sense above source
  assign over_view = {ch2_sense_over_flag, ch2_source_over_flag, ch1_sense_over_flag, ch1_source_over_flag};
  assign under_view = {ch2_sense_under_flag, ch2_source_under_flag, ch1_sense_under_flag, ch1_source_under_flag};
  assign mask_view = {ch2_sense_limit_mask, ch2_source_limit_mask, ch1_sense_limit_mask, ch1_source_limit_mask};

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  // Read data selection, held between reads
  always_comb begin
    rdata_next = rdata_reg;
    if (reg_rd) begin
      case (reg_addr)
        ADDR_RATE: rdata_next = {6'h00, rate_reg};
        ADDR_TRIGGER: rdata_next = 8'h00;
        ADDR_MASKS: rdata_next = {4'h0, mask_view};
        ADDR_OVER: rdata_next = {done_reg, 3'h0, over_view};
        ADDR_UNDER: rdata_next = {4'h0, under_view};
        ADDR_SAMPLING: rdata_next = sampling_reg;
        default: rdata_next = 8'h00;
      endcase
    end
  end

  // Read data register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata_reg <= 8'h00;
    end else if (ce) begin
      rdata_reg <= rdata_next;
    end
  end

  // ---------------------------------------------------------------
  // Alert output
  // ---------------------------------------------------------------
  localparam int PW = $clog2(DONE_PULSE_CYCLES + 1);
  localparam logic [PW-1:0] PULSE_LEN = PW'(DONE_PULSE_CYCLES);
  logic [PW-1:0] pulse_reg;
  logic [PW-1:0] pulse_next;
  logic alert_n_reg;
  logic alert_n_next;
  logic limit_cause;

  assign limit_cause = |((over_view | under_view) & ~mask_view & impl_mask);

  // Done pulse countdown and alert level
  always_comb begin
    pulse_next = pulse_reg;
    if (pulse_reg != '0) begin
      pulse_next = pulse_reg - PW'(1);
    end
    if (cycle_done && cycle_done_alert_pulse) begin
      pulse_next = PULSE_LEN;
    end
    alert_n_next = !((limit_cause && !global_alert_mask) || (pulse_next != '0));
  end

  // Pulse counter and alert pin register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pulse_reg <= '0;
      alert_n_reg <= 1'b1;
    end else if (ce) begin
      pulse_reg <= pulse_next;
      alert_n_reg <= alert_n_next;
    end
  end

  // Outputs straight from flops
  assign reg_rdata = rdata_reg;
  assign start_conversion = start_reg;
  assign sample_rate_code = rate_reg;
  assign sampling_setup = sampling_reg;
  assign alert_n = alert_n_reg;

endmodule

/* File: verification/regs_checker.sv */
`timescale 1ns/1ps
module regs_checker
  import monitor_regs_pkg::*;
#(
  parameter bit DUAL = 1'b1
) (
  // Clock, enable and reset
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // Register access
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Conversion side and alert
  input wire logic global_alert_mask,
  input wire logic cycle_done_alert_pulse,
  input wire logic standby,
  input wire logic cycle_done,
  input wire logic [3:0] meas_valid,
  input wire logic [3:0] at_or_above_high,
  input wire logic [3:0] below_low,
  input wire logic start_conversion,
  input wire logic [1:0] sample_rate_code,
  input wire logic [7:0] sampling_setup,
  input wire logic alert_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  logic [3:0] mask_reg;
  logic [3:0] mask_next;
  logic [3:0] impl_bits;
  wire wr_trig = reg_wr && reg_addr == ADDR_TRIGGER;
  // Measurements present in this build
  assign impl_bits = DUAL ? 4'hf : 4'h3;
  // Shadow of the mask register
  always_comb begin
    mask_next = mask_reg;
    if (reg_wr && reg_addr == ADDR_MASKS) begin
      mask_next = reg_wdata[3:0] & impl_bits;
    end
  end
  // Register the shadow, frozen with the enable
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mask_reg <= MASKS_RESET;
    end else if (ce) begin
      mask_reg <= mask_next;
    end
  end
  a_trig_start: assert property (ce && wr_trig && standby |=> start_conversion)
    else $error("standby trigger gave no start");
  a_start_cause: assert property (start_conversion && $past(ce) |-> $past(wr_trig && standby))
    else $error("start without standby trigger");
  a_rate_write: assert property (ce && reg_wr && reg_addr == ADDR_RATE |=>
    sample_rate_code == $past(reg_wdata[1:0]))
    else $error("rate code not taken");
  a_sampling_write: assert property (ce && reg_wr && reg_addr == ADDR_SAMPLING |=>
    sampling_setup == ($past(reg_wdata) & (DUAL ? 8'hff : 8'h0f)))
    else $error("sampling fields not taken");
  a_rate_unused: assert property (ce && reg_rd && reg_addr == ADDR_RATE |=> reg_rdata[7:2] == 6'h00)
    else $error("rate upper bits not zero");
  a_mask_read: assert property (ce && reg_rd && reg_addr == ADDR_MASKS |=>
    reg_rdata == {4'h0, $past(mask_reg)})
    else $error("mask readback wrong");
  a_done_pulse: assert property (ce && cycle_done && cycle_done_alert_pulse |=> !alert_n [*8])
    else $error("done pulse missing");
  a_flag_alert: assert property (ce && !global_alert_mask &&
    |(meas_valid & (at_or_above_high | below_low) & ~mask_reg & impl_bits) |-> ##2 !alert_n)
    else $error("unmasked flag left alert high");
  c_trigger: cover property (wr_trig && standby);
  c_alert: cover property ($fell(alert_n));
  c_over_read: cover property (reg_rd && reg_addr == ADDR_OVER);
endmodule

bind monitor_rate_mask_status_regs regs_checker #(.DUAL(DUAL)) chk (.clk(clk), .nrst(nrst), .ce(ce),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .global_alert_mask(global_alert_mask), .cycle_done_alert_pulse(cycle_done_alert_pulse),
  .standby(standby), .cycle_done(cycle_done), .meas_valid(meas_valid), .at_or_above_high(at_or_above_high),
  .below_low(below_low), .start_conversion(start_conversion), .sample_rate_code(sample_rate_code),
  .sampling_setup(sampling_setup), .alert_n(alert_n));

/* File: verification/sample_rate_code_engine_model.sv */
`timescale 1ns/1ps
module sample_rate_code_engine_model #(
  parameter int DELAY = 4
) (
  // Clock and start
  input wire logic clk,
  input wire logic start,
  // Compare patterns to report
  input wire logic [3:0] hi_pat,
  input wire logic [3:0] lo_pat,
  // Results toward the block
  output logic done,
  output logic [3:0] valid,
  output logic [3:0] above,
  output logic [3:0] below
);
  int cnt = 0;
  // Results stand only in the valid cycle, inverted elsewhere
  always @(negedge clk) begin
    done <= 1'b0;
    valid <= 4'h0;
    above <= ~hi_pat;
    below <= ~lo_pat;
    if (start) begin
      cnt <= DELAY;
    end else if (cnt == 1) begin
      done <= 1'b1;
      valid <= 4'hf;
      above <= hi_pat;
      below <= lo_pat;
      cnt <= 0;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
endmodule

/* File: verification/monitor_rate_mask_status_regs_tb.sv */
`timescale 1ns/1ps
module monitor_rate_mask_status_regs_tb;
  import monitor_regs_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic global_alert_mask = 1'b0;
  logic cycle_done_alert_pulse = 1'b0;
  logic standby = 1'b0;
  logic [3:0] hi_pat = 4'h0;
  logic [3:0] lo_pat = 4'h0;
  logic cycle_done, start_conversion, alert_n;
  logic [3:0] meas_valid, above, below;
  logic [1:0] sample_rate_code;
  logic [7:0] sampling_setup, reg_rdata;
  logic [7:0] rdata_s, sampling_s;
  logic ce = 1'b1;
  int failures = 0;
  int n_checks = 0;
  int len = 0;
  always #10 clk = ~clk;
  monitor_rate_mask_status_regs #(.DUAL(1'b1)) uut (.clk(clk), .nrst(nrst), .ce(ce),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .global_alert_mask(global_alert_mask), .cycle_done_alert_pulse(cycle_done_alert_pulse),
    .standby(standby), .cycle_done(cycle_done), .meas_valid(meas_valid), .at_or_above_high(above),
    .below_low(below), .start_conversion(start_conversion), .sample_rate_code(sample_rate_code),
    .sampling_setup(sampling_setup), .alert_n(alert_n));
  // Single-channel build on the same stimulus
  monitor_rate_mask_status_regs #(.DUAL(1'b0)) uut_single (.clk(clk), .nrst(nrst), .ce(ce),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata_s),
    .global_alert_mask(global_alert_mask), .cycle_done_alert_pulse(cycle_done_alert_pulse),
    .standby(standby), .cycle_done(cycle_done), .meas_valid(meas_valid), .at_or_above_high(above),
    .below_low(below), .start_conversion(), .sample_rate_code(),
    .sampling_setup(sampling_s), .alert_n());
  sample_rate_code_engine_model #(.DELAY(4)) eng (.clk(clk), .start(start_conversion), .hi_pat(hi_pat),
    .lo_pat(lo_pat), .done(cycle_done), .valid(meas_valid), .above(above), .below(below));
  // Compare and count
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  // One write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  // One read strobe, data compared a cycle later
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    check(reg_rdata, exp);
  endtask
  // Trigger a cycle and let it finish
  task automatic convert;
    wr(ADDR_TRIGGER, 8'h00);
    repeat (8) @(negedge clk);
  endtask
  task automatic print_verdict;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Watchdog
  initial begin
    #100000;
    failures++;
    print_verdict;
  end
  // Main sequence
  initial begin
    repeat (12) @(negedge clk);
    nrst = 1'b1;
    rd(ADDR_RATE, 8'h03);
    rd(ADDR_TRIGGER, 8'h00);
    rd(ADDR_MASKS, 8'h00);
    rd(ADDR_OVER, 8'h00);
    rd(ADDR_UNDER, 8'h00);
    rd(ADDR_SAMPLING, 8'h00);
    rd(8'h07, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_RATE, 8'hfc | 8'(i));
      rd(ADDR_RATE, 8'(i));
      check({6'h00, sample_rate_code}, 8'(i));
    end
    wr(ADDR_MASKS, 8'hff);
    rd(ADDR_MASKS, 8'h0f);
    check(rdata_s, 8'h03);
    wr(ADDR_SAMPLING, 8'ha5);
    rd(ADDR_SAMPLING, 8'ha5);
    check(rdata_s, 8'h05);
    check(sampling_setup, 8'ha5);
    check(sampling_s, 8'h05);
    ce = 1'b0;
    wr(ADDR_RATE, 8'h01);
    ce = 1'b1;
    check({6'h00, sample_rate_code}, 8'h03);
    $display("test fields done");
    wr(ADDR_TRIGGER, 8'h5a);
    check({7'h00, start_conversion}, 8'h00);
    standby = 1'b1;
    hi_pat = 4'h3;
    lo_pat = 4'hc;
    wr(ADDR_TRIGGER, 8'h00);
    check({7'h00, start_conversion}, 8'h01);
    repeat (8) @(negedge clk);
    check({7'h00, alert_n}, 8'h01);
    rd(ADDR_OVER, 8'h83);
    rd(ADDR_OVER, 8'h00);
    rd(ADDR_UNDER, 8'h0c);
    check(rdata_s, 8'h00);
    rd(ADDR_UNDER, 8'h00);
    $display("test flags done");
    wr(ADDR_MASKS, 8'h0e);
    hi_pat = 4'h1;
    lo_pat = 4'h0;
    global_alert_mask = 1'b1;
    convert;
    check({7'h00, alert_n}, 8'h01);
    rd(ADDR_OVER, 8'h81);
    global_alert_mask = 1'b0;
    convert;
    check({7'h00, alert_n}, 8'h00);
    rd(ADDR_OVER, 8'h81);
    repeat (2) @(negedge clk);
    check({7'h00, alert_n}, 8'h01);
    $display("test alert done");
    wr(ADDR_MASKS, 8'hff);
    cycle_done_alert_pulse = 1'b1;
    wr(ADDR_TRIGGER, 8'h00);
    for (int k = 0; k < 20 && alert_n; k++) @(negedge clk);
    while (!alert_n && len < 400) begin
      len++;
      @(negedge clk);
    end
    check(8'(len), 8'(DONE_PULSE_CYCLES));
    cycle_done_alert_pulse = 1'b0;
    $display("test pulse done");
    print_verdict;
  end
endmodule
